//--- core/cpr_pkg.sv
package cpr_pkg;

	// ==========================================================
	// Register map (index = printed offset, byte address = index * 4)
	localparam logic [7:0] CPR_POWER_CONTROL_REGISTER_IDX = 8'h87;
	localparam logic [7:0] CPR_AUXILIARY_REGISTER_IDX = 8'h8E;
	localparam logic [7:0] CPR_STAT_IDX = 8'h8F;
	localparam int CPR_ADDR_W = 12;
	localparam logic [11:0] CPR_POWER_CONTROL_REGISTER_ADDR = {2'b00, CPR_POWER_CONTROL_REGISTER_IDX, 2'b00};
	localparam logic [11:0] CPR_AUXILIARY_REGISTER_ADDR = {2'b00, CPR_AUXILIARY_REGISTER_IDX, 2'b00};
	localparam logic [11:0] CPR_STAT_ADDR = {2'b00, CPR_STAT_IDX, 2'b00};

	// ==========================================================
	// Power control register fields
	localparam int CPR_POWER_CONTROL_REGISTER_IDLE_BIT = 0;
	localparam int CPR_POWER_CONTROL_REGISTER_PD_BIT = 1;
	localparam int CPR_POWER_CONTROL_REGISTER_GF0_BIT = 2;
	localparam int CPR_POWER_CONTROL_REGISTER_GF1_BIT = 3;
	localparam int CPR_POWER_CONTROL_REGISTER_POF_BIT = 4;
	localparam int CPR_POWER_CONTROL_REGISTER_SMOD_BIT = 7;
	localparam logic [7:0] CPR_POWER_CONTROL_REGISTER_RST = 8'h00;
	localparam logic [7:0] CPR_POWER_CONTROL_REGISTER_WMASK = 8'h8F;

	// Auxiliary register fields
	localparam int CPR_AUXILIARY_REGISTER_STROBE_OFF_BIT = 0;
	localparam logic [7:0] CPR_AUXILIARY_REGISTER_RST = 8'h00;

	// Status register fields
	localparam int CPR_STAT_LOCK_BIT = 0;
	localparam int CPR_STAT_RESTRICT_BIT = 1;
	localparam int CPR_STAT_CORE_RST_BIT = 2;
	localparam int CPR_STAT_FLASH_BIT = 3;
	localparam int CPR_STAT_CPU_RUN_BIT = 4;

	// ==========================================================
	// Machine cycle timing, in oscillator clocks; reset hold in machine cycles
	localparam logic [3:0] CPR_OSC_PER_MCYCLE = 4'd12;
	localparam logic [3:0] CPR_ALE_PERIOD = 4'd6;
	localparam logic [3:0] CPR_ALE_HI_SLOTS = 4'd2;
	localparam logic [3:0] CPR_STATE5_PHASE2_SAMPLE_POINT_SLOT = 4'd9;
	localparam logic [1:0] CPR_RST_HOLD_MCYCLES = 2'd2;

	// Reset glitch filter
	localparam int CPR_CLK_PS = 4000;
	localparam int CPR_DEGLITCH_NS = 100;
	localparam int CPR_DEGLITCH_CYC = (CPR_DEGLITCH_NS * 1000 + CPR_CLK_PS - 1) / CPR_CLK_PS;
	localparam int CPR_DEGLITCH_W = 5;

endpackage

//--- core/cpr_sync.sv
`timescale 1ns/1ps
module cpr_sync (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Level in and out
	input wire logic async_in,
	output logic sync_out
);

	logic meta_ff;

	// Two flops; the first is read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule

//--- core/cpr_deglitch.sv
`timescale 1ns/1ps
module cpr_deglitch #(
	parameter int CNT_W = 5,
	parameter logic [CNT_W-1:0] STABLE_CYC = 5'd25
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Filtered level
	input wire logic level_in,
	output logic level_out
);

	logic [CNT_W-1:0] cnt_ff;

	// Output follows input only after it differs for STABLE_CYC clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
			level_out <= 1'b0;
		end else if (level_in == level_out) begin
			cnt_ff <= '0;
		end else if (cnt_ff >= STABLE_CYC - 1'b1) begin
			cnt_ff <= '0;
			level_out <= level_in;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

endmodule

//--- core/cpr_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Address latch strobe pulses at one sixth of the oscillator rate.
// - One strobe pulse is skipped during each external data memory access.
// - During reset the address latch strobe pin is released, weak pull-up.
// - Program store strobe goes low for external fetches and granted code-memory reads of external space.
// - During reset the program store strobe pin is released, weak pull-up.
// - Oscillator clock is halved into phases before internal use.
// - Idle request stops the processor clock; peripherals keep running.
// - Idle ends on any enabled interrupt or on reset.
// - Power-down request stops every clock, oscillator included.
// - Only reset leaves power-down; interrupts do not.
// - Reset pin sampled at state 5 phase 2; two machine cycles needed.
// - Reset pin is filtered so short glitches are ignored.
// - Reset clears special registers except power-off flag; core inits ports, stack.
// - Lock bit at 0 refuses all external flash reads.
// - Restrict bit 0: external-space code reads reach external memory only.
// - Internal-space code reads always reach internal and external memory.
// - Restrict bit 1 places no limit on code-memory reads.
// - Power-off flag set at power-on, kept by other resets, software clears.
// - Strobe-off bit stops the address latch strobe toggling.
// - With strobe off, external code or data accesses still pulse it.
module cpr_ctrl (
	// APB clock and power-on reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cpr_pkg::CPR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device pins
	input wire logic reset_pin,
	input wire logic flash_mode_pin,
	input wire logic ale_pin_in,
	output logic ale_pin_out,
	output logic ale_pin_oe,
	input wire logic program_store_strobe_in,
	output logic program_store_strobe_n_out,
	output logic program_store_strobe_oe,
	// Nonvolatile option bits
	input wire logic nv_lock_bit,
	input wire logic nv_code_read_restrict_bit,
	// Core requests, same clock
	input wire logic ext_code_fetch,
	input wire logic ext_data_access,
	input wire logic irq_pending,
	input wire logic code_read_req,
	input wire logic code_read_from_internal,
	input wire logic code_read_target_internal,
	input wire logic ext_flash_read_req,
	// Clock and reset controls to the rest of the chip
	output logic phase_clk,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_enable,
	output logic core_reset,
	output logic smod_bit,
	output logic code_read_grant,
	output logic ext_flash_read_ok,
	output logic flash_op_select
);
	import cpr_pkg::*;

	// ==========================================================
	// Pin synchronisers and reset filter
	logic rst_sync;
	logic rst_filt;
	logic flash_sync;
	logic ale_in_sync;
	logic program_store_strobe_in_sync;

	cpr_sync u_rst_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(reset_pin),
		.sync_out(rst_sync)
	);

	cpr_sync u_flash_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(flash_mode_pin),
		.sync_out(flash_sync)
	);

	cpr_sync u_ale_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(ale_pin_in),
		.sync_out(ale_in_sync)
	);

	cpr_sync u_program_store_strobe_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(program_store_strobe_in),
		.sync_out(program_store_strobe_in_sync)
	);

	// Glitches shorter than the filter time never reach the sampler
	cpr_deglitch #(
		.CNT_W(CPR_DEGLITCH_W),
		.STABLE_CYC(CPR_DEGLITCH_W'(CPR_DEGLITCH_CYC))
	) u_rst_filter (
		.pclk(pclk),
		.presetn(presetn),
		.level_in(rst_sync),
		.level_out(rst_filt)
	);

	// ==========================================================
	// State and phase counter
	logic [3:0] osc_cnt_ff;
	logic [3:0] nxt_osc_cnt;
	logic pd_ff;
	logic idle_ff;
	logic [3:0] ale_slot;
	logic state5_phase2_sample_point;
	logic ale_hold;

	// Counter freezes while the oscillator is stopped, but only once a started strobe pulse is whole
	always_comb begin
		if (pd_ff && !ale_hold) begin
			nxt_osc_cnt = osc_cnt_ff;
		end else if (osc_cnt_ff == CPR_OSC_PER_MCYCLE - 1'b1) begin
			nxt_osc_cnt = 4'd0;
		end else begin
			nxt_osc_cnt = osc_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt_ff <= 4'd0;
		end else begin
			osc_cnt_ff <= nxt_osc_cnt;
		end
	end

	// Halved clock: one phase per oscillator period
	assign phase_clk = osc_cnt_ff[0];
	assign ale_slot = (osc_cnt_ff >= CPR_ALE_PERIOD) ? osc_cnt_ff - CPR_ALE_PERIOD : osc_cnt_ff;
	assign state5_phase2_sample_point = (osc_cnt_ff == CPR_STATE5_PHASE2_SAMPLE_POINT_SLOT) && !pd_ff;
	// A pulse that has started always runs its full high time, so no sliver reaches the latch
	assign ale_hold = ale_pin_out && (ale_slot != 4'd0) && (ale_slot < CPR_ALE_HI_SLOTS);

	// ==========================================================
	// Reset sampling
	logic [1:0] rst_hits_ff;
	logic core_rst_ff;

	// Two consecutive high samples at state 5 phase 2 make a reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_hits_ff <= 2'd0;
			core_rst_ff <= 1'b1;
		end else if (state5_phase2_sample_point) begin
			if (!rst_filt) begin
				rst_hits_ff <= 2'd0;
				core_rst_ff <= 1'b0;
			end else if (rst_hits_ff >= CPR_RST_HOLD_MCYCLES - 1'b1) begin
				rst_hits_ff <= CPR_RST_HOLD_MCYCLES;
				core_rst_ff <= 1'b1;
			end else begin
				rst_hits_ff <= rst_hits_ff + 1'b1;
			end
		end
	end

	assign core_reset = core_rst_ff;

	// ==========================================================
	// Option bits
	logic opt_loaded_ff;
	logic lock_ff;
	logic restrict_ff;

	// Captured while reset is held, then frozen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_loaded_ff <= 1'b0;
			lock_ff <= 1'b0;
			restrict_ff <= 1'b0;
		end else if (!opt_loaded_ff || core_rst_ff) begin
			opt_loaded_ff <= 1'b1;
			lock_ff <= nv_lock_bit;
			restrict_ff <= nv_code_read_restrict_bit;
		end
	end

	// ==========================================================
	// APB slave, zero wait states
	logic wr_en;
	logic rd_en;
	logic hit_power_control_register;
	logic hit_auxiliary_register;
	logic hit_stat;
	logic [7:0] power_control_register_ff;
	logic pof_ff;
	logic [7:0] auxiliary_register_ff;
	logic [7:0] stat_val;

	assign hit_power_control_register = (paddr == CPR_POWER_CONTROL_REGISTER_ADDR);
	assign hit_auxiliary_register = (paddr == CPR_AUXILIARY_REGISTER_ADDR);
	assign hit_stat = (paddr == CPR_STAT_ADDR);
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(hit_power_control_register || hit_auxiliary_register || hit_stat);

	assign stat_val = {3'b000, cpu_clk_en, flash_sync, core_rst_ff, restrict_ff, lock_ff};

	// Read data loaded at the setup edge so it stands through the access phase; unmapped reads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && hit_power_control_register) begin
			prdata <= {24'h00_0000, power_control_register_ff[7:5], pof_ff, power_control_register_ff[3:0]};
		end else if (rd_en && hit_auxiliary_register) begin
			prdata <= {24'h00_0000, auxiliary_register_ff};
		end else if (rd_en && hit_stat) begin
			prdata <= {24'h00_0000, stat_val};
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Power control register (idle and power-down kept apart)
	logic wake_idle;
	assign wake_idle = irq_pending || core_rst_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_control_register_ff <= CPR_POWER_CONTROL_REGISTER_RST;
		end else if (core_rst_ff) begin
			power_control_register_ff <= CPR_POWER_CONTROL_REGISTER_RST & ~CPR_POWER_CONTROL_REGISTER_WMASK;
		end else if (wr_en && hit_power_control_register) begin
			power_control_register_ff <= pwdata[7:0] & CPR_POWER_CONTROL_REGISTER_WMASK;
		end
	end

	// Power-off flag: set by power-on only, software writes 0 to clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pof_ff <= 1'b1;
		end else if (wr_en && hit_power_control_register && !pwdata[CPR_POWER_CONTROL_REGISTER_POF_BIT]) begin
			pof_ff <= 1'b0;
		end
	end

	// Idle: software sets, interrupt or reset clears; set wins over interrupt, reset wins over set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_ff <= 1'b0;
		end else if (wr_en && hit_power_control_register && pwdata[CPR_POWER_CONTROL_REGISTER_IDLE_BIT] && !core_rst_ff) begin
			idle_ff <= 1'b1;
		end else if (wake_idle) begin
			idle_ff <= 1'b0;
		end
	end

	// Power-down: only the filtered reset pin ends it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_ff <= 1'b0;
		end else if (rst_filt || core_rst_ff) begin
			pd_ff <= 1'b0;
		end else if (wr_en && hit_power_control_register && pwdata[CPR_POWER_CONTROL_REGISTER_PD_BIT]) begin
			pd_ff <= 1'b1;
		end
	end

	assign smod_bit = power_control_register_ff[CPR_POWER_CONTROL_REGISTER_SMOD_BIT];

	// Clock enables to the rest of the chip
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			osc_enable <= 1'b1;
		end else begin
			cpu_clk_en <= !idle_ff && !pd_ff;
			periph_clk_en <= !pd_ff;
			osc_enable <= !pd_ff;
		end
	end

	// ==========================================================
	// Auxiliary register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auxiliary_register_ff <= CPR_AUXILIARY_REGISTER_RST;
		end else if (core_rst_ff) begin
			auxiliary_register_ff <= CPR_AUXILIARY_REGISTER_RST;
		end else if (wr_en && hit_auxiliary_register) begin
			auxiliary_register_ff <= {7'b000_0000, pwdata[CPR_AUXILIARY_REGISTER_STROBE_OFF_BIT]};
		end
	end

	// ==========================================================
	// Address latch and program store strobes
	logic ale_pulse;
	logic ale_skip;
	logic ale_active;
	logic program_store_strobe_low;
	logic pin_release;

	// Second pulse of a data-access machine cycle is dropped
	assign ale_skip = ext_data_access && (osc_cnt_ff >= CPR_ALE_PERIOD);
	assign ale_active = !auxiliary_register_ff[CPR_AUXILIARY_REGISTER_STROBE_OFF_BIT] || ext_code_fetch || ext_data_access;
	assign ale_pulse = ((ale_slot == 4'd0) && !ale_skip && ale_active && !pd_ff) || ale_hold;
	assign program_store_strobe_low = ((ext_code_fetch || (code_read_req && code_read_grant && !code_read_target_internal))
		&& (ale_slot >= CPR_ALE_HI_SLOTS) && !pd_ff);
	assign pin_release = core_rst_ff || flash_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ale_pin_out <= 1'b0;
			ale_pin_oe <= 1'b0;
			program_store_strobe_n_out <= 1'b1;
			program_store_strobe_oe <= 1'b0;
		end else begin
			ale_pin_out <= ale_pulse && (!pin_release || ale_hold);
			ale_pin_oe <= !pin_release || ale_hold;
			program_store_strobe_n_out <= !program_store_strobe_low || pin_release;
			program_store_strobe_oe <= !pin_release;
		end
	end

	// Flash mode: programmer drives both pins as operation selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_op_select <= 1'b0;
		end else begin
			flash_op_select <= flash_sync && !ale_in_sync && program_store_strobe_in_sync;
		end
	end

	// ==========================================================
	// Code protection
	always_comb begin
		if (restrict_ff) begin
			code_read_grant = code_read_req;
		end else if (code_read_from_internal) begin
			code_read_grant = code_read_req;
		end else begin
			code_read_grant = code_read_req && !code_read_target_internal;
		end
	end

	assign ext_flash_read_ok = ext_flash_read_req && lock_ff;

endmodule

//--- bench/cpr_chk.sv
`timescale 1ns/1ps
module cpr_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Core requests
	input wire logic ext_code_fetch,
	input wire logic code_read_req,
	input wire logic code_read_from_internal,
	input wire logic ext_flash_read_req,
	// Strobe pins
	input wire logic ale_pin_out,
	input wire logic ale_pin_oe,
	input wire logic program_store_strobe_n_out,
	input wire logic program_store_strobe_oe,
	// Clock controls and grants
	input wire logic phase_clk,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic osc_enable,
	input wire logic core_reset,
	input wire logic code_read_grant,
	input wire logic ext_flash_read_ok,
	input wire logic flash_op_select
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Strobe shape: two cycles high, then at least four low
	sequence s_ale_pulse;
		ale_pin_out ##1 !ale_pin_out [*4];
	endsequence
	ale_period_a: assert property ($rose(ale_pin_out) |=> s_ale_pulse)
		else $error("strobe pulse shape wrong");
	rst_release_a: assert property (core_reset [*2] |-> !ale_pin_oe && !program_store_strobe_oe)
		else $error("strobe pin driven in reset");
	program_store_strobe_cause_a: assert property (program_store_strobe_oe && !program_store_strobe_n_out |->
		$past(ext_code_fetch) || $past(code_read_grant))
		else $error("program strobe low without a fetch");
	// Halved clock toggles every cycle while the oscillator runs
	phase_div_a: assert property (osc_enable && $past(osc_enable) && $past(presetn) |->
		phase_clk != $past(phase_clk))
		else $error("phase clock not toggling");
	idle_periph_a: assert property (!cpu_clk_en && osc_enable |-> periph_clk_en)
		else $error("peripheral clock stopped in idle");
	pd_all_a: assert property (!osc_enable ##1 !osc_enable |-> !cpu_clk_en && !periph_clk_en)
		else $error("clock running in power down");
	grant_int_a: assert property (code_read_req && code_read_from_internal && !core_reset |->
		code_read_grant)
		else $error("internal code read refused");
	grant_req_a: assert property (code_read_grant |-> code_read_req)
		else $error("grant without request");
	flash_ok_a: assert property (ext_flash_read_ok |-> ext_flash_read_req)
		else $error("flash read allowed without request");
	flash_pins_a: assert property (flash_op_select |-> !ale_pin_oe && !program_store_strobe_oe)
		else $error("strobe pins driven in flash mode");
endmodule

bind cpr_ctrl cpr_chk u_chk (.pclk(pclk), .presetn(presetn), .ext_code_fetch(ext_code_fetch),
	.code_read_req(code_read_req), .code_read_from_internal(code_read_from_internal),
	.ext_flash_read_req(ext_flash_read_req), .ale_pin_out(ale_pin_out), .ale_pin_oe(ale_pin_oe),
	.program_store_strobe_n_out(program_store_strobe_n_out), .program_store_strobe_oe(program_store_strobe_oe),
	.phase_clk(phase_clk), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
	.core_reset(core_reset), .code_read_grant(code_read_grant), .ext_flash_read_ok(ext_flash_read_ok),
	.flash_op_select(flash_op_select));

//--- bench/cpr_mem_model.sv
`timescale 1ns/1ps
module cpr_mem_model (
	// Clock
	input wire logic pclk,
	// Programmer mode select
	input wire logic flash_mode,
	// Strobe pins from the device
	input wire logic ale_out,
	input wire logic ale_oe,
	input wire logic ps_n_out,
	input wire logic ps_oe,
	// Resolved pin levels
	output logic ale_wire,
	output logic ps_wire,
	output int latch_cnt
);
	logic ale_q = 1'b1;
	int cnt = 0;
	// Released pins float high; the programmer pulls latch strobe low in flash mode
	assign ale_wire = ale_oe ? ale_out : !flash_mode;
	assign ps_wire = ps_oe ? ps_n_out : 1'b1;
	assign latch_cnt = cnt;
	// Address latch captures on each falling strobe edge
	always @(posedge pclk) begin
		ale_q <= ale_wire;
		if (ale_q && !ale_wire) begin
			cnt <= cnt + 1;
		end
	end
endmodule

//--- bench/mcu_clock_reset_power_ctrl_tb_top.sv
`timescale 1ns/1ps
module mcu_clock_reset_power_ctrl_tb_top;
	import cpr_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, c, prdata;
	logic reset_pin = 0, flash_mode_pin = 0, nv_lock_bit = 1, nv_code_read_restrict_bit = 0;
	logic ext_code_fetch = 0, ext_data_access = 0, irq_pending = 0, code_read_req = 0;
	logic code_read_from_internal = 0, code_read_target_internal = 0, ext_flash_read_req = 0;
	logic pready, pslverr, ale_pin_out, ale_pin_oe, program_store_strobe_n_out, program_store_strobe_oe;
	logic phase_clk, cpu_clk_en, periph_clk_en, osc_enable, core_reset, smod_bit;
	logic code_read_grant, ext_flash_read_ok, flash_op_select, ale_wire, ps_wire;
	int err_total = 0, compares = 0, seed = 2, latch_cnt;

	always #2 pclk = ~pclk;

	cpr_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.reset_pin, .flash_mode_pin, .ale_pin_in(ale_wire), .ale_pin_out, .ale_pin_oe,
		.program_store_strobe_in(ps_wire), .program_store_strobe_n_out, .program_store_strobe_oe,
		.nv_lock_bit, .nv_code_read_restrict_bit, .ext_code_fetch, .ext_data_access, .irq_pending,
		.code_read_req, .code_read_from_internal, .code_read_target_internal, .ext_flash_read_req,
		.phase_clk, .cpu_clk_en, .periph_clk_en, .osc_enable, .core_reset, .smod_bit, .code_read_grant,
		.ext_flash_read_ok, .flash_op_select);
	cpr_mem_model u_mem (.pclk, .flash_mode(flash_mode_pin), .ale_out(ale_pin_out), .ale_oe(ale_pin_oe),
		.ps_n_out(program_store_strobe_n_out), .ps_oe(program_store_strobe_oe), .ale_wire, .ps_wire, .latch_cnt);

	// ==========================================================
	// Helpers
	task tally_and_finish;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; response and read data are taken at the access edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			tally_and_finish;
		end
		slv = pslverr;
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	// Bounded wait for a control output to reach a level
	task wt(input int s, input logic v);
		logic x;
		for (int n = 0; n < 400; n++) begin
			@(posedge pclk);
			x = (s == 0) ? core_reset : (s == 1) ? cpu_clk_en : flash_op_select;
			if (x === v) return;
		end
		err_total++;
		tally_and_finish;
	endtask
	task pulses(input int n, output logic [31:0] cnt);
		int c0;
		c0 = latch_cnt;
		repeat (n) @(posedge pclk);
		cnt = 32'(latch_cnt - c0);
	endtask
	// Sweep every source and target space of a code read
	task grants(input logic r);
		for (int i = 0; i < 4; i++) begin
			code_read_req <= 1;
			code_read_from_internal <= i[0];
			code_read_target_internal <= i[1];
			@(posedge pclk);
			chk(32'(code_read_grant), 32'(r | i[0] | !i[1]));
		end
		code_read_req <= 0;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] d;
		repeat (2) @(posedge pclk);
		chk(32'(ale_wire), 32'h1);
		chk(32'(ps_wire), 32'h1);
		presetn <= 1;
		wt(0, 0);
		apb(0, CPR_POWER_CONTROL_REGISTER_ADDR, 0);
		chk(rd, 32'h0000_0010);
		apb(0, CPR_AUXILIARY_REGISTER_ADDR, 0);
		chk(rd, 32'h0);
		apb(0, CPR_STAT_ADDR, 0);
		chk(rd, 32'h0000_0011);
		pulses(60, c);
		chk(c, 32'd10);
		ext_data_access <= 1;
		repeat (12) @(posedge pclk);
		pulses(12, c);
		chk(c, 32'd1);
		ext_data_access <= 0;
		apb(1, CPR_AUXILIARY_REGISTER_ADDR, 32'h1);
		repeat (4) @(posedge pclk);
		pulses(24, c);
		chk(c, 32'd0);
		ext_code_fetch <= 1;
		repeat (12) @(posedge pclk);
		pulses(24, c);
		chk(c, 32'd4);
		// Program strobe low in eight of every twelve cycles of a fetch
		d = 32'h0000_0000;
		repeat (12) begin
			@(posedge pclk);
			d = d + 32'(!ps_wire);
		end
		chk(d, 32'd8);
		ext_code_fetch <= 0;
		repeat (12) @(posedge pclk);
		pulses(24, c);
		chk(c, 32'd0);
		apb(1, CPR_AUXILIARY_REGISTER_ADDR, 32'h0);
		// Random flag and baud bits read back
		repeat (6) begin
			d = $random(seed) & 32'h0000_008C;
			apb(1, CPR_POWER_CONTROL_REGISTER_ADDR, d);
			apb(0, CPR_POWER_CONTROL_REGISTER_ADDR, 0);
			chk(rd, d);
		end
		apb(1, 12'h100, 32'hFFFF_FFFF);
		chk(32'(slv), 32'h1);
		apb(0, 12'h100, 0);
		chk(rd, 32'h0);
		grants(0);
		ext_flash_read_req <= 1;
		@(posedge pclk);
		chk(32'(ext_flash_read_ok), 32'h1);
		ext_flash_read_req <= 0;
		// Idle then wake by interrupt
		apb(1, CPR_POWER_CONTROL_REGISTER_ADDR, 32'h1);
		repeat (3) @(posedge pclk);
		chk(32'(cpu_clk_en), 32'h0);
		chk(32'(periph_clk_en), 32'h1);
		irq_pending <= 1;
		wt(1, 1);
		irq_pending <= 0;
		// Power down ignores interrupts and glitches
		apb(1, CPR_POWER_CONTROL_REGISTER_ADDR, 32'h2);
		repeat (3) @(posedge pclk);
		chk({29'h0, osc_enable, cpu_clk_en, periph_clk_en}, 32'h0);
		irq_pending <= 1;
		repeat (40) @(posedge pclk);
		chk(32'(osc_enable), 32'h0);
		irq_pending <= 0;
		reset_pin <= 1;
		repeat (10) @(posedge pclk);
		reset_pin <= 0;
		repeat (60) @(posedge pclk);
		chk(32'(core_reset), 32'h0);
		chk(32'(osc_enable), 32'h0);
		nv_lock_bit <= 0;
		nv_code_read_restrict_bit <= 1;
		reset_pin <= 1;
		wt(0, 1);
		repeat (30) @(posedge pclk);
		chk(32'(osc_enable), 32'h1);
		apb(0, CPR_POWER_CONTROL_REGISTER_ADDR, 0);
		chk(rd, 32'h0);
		reset_pin <= 0;
		wt(0, 0);
		nv_lock_bit <= 1;
		apb(0, CPR_STAT_ADDR, 0);
		chk(rd, 32'h0000_0012);
		grants(1);
		ext_flash_read_req <= 1;
		@(posedge pclk);
		@(posedge pclk);
		chk(32'(ext_flash_read_ok), 32'h0);
		ext_flash_read_req <= 0;
		flash_mode_pin <= 1;
		wt(2, 1);
		chk({30'h0, ale_pin_oe, program_store_strobe_oe}, 32'h0);
		flash_mode_pin <= 0;
		tally_and_finish;
	end
endmodule
